// File: include/wdt_defs.svh
// register indices, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define WDT_IDX_CTRL        16'h0000
`define WDT_IDX_STAT        16'h0001
`define WDT_IDX_SERVICE     16'hffff

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define WDT_CTRL_DISABLE    0
`define WDT_CTRL_RATE       1
`define WDT_CTRL_STOP_EN    2
`define WDT_STAT_CAUSE      0
`define WDT_STAT_CNT_LSB    8
`define WDT_STAT_DRIVE      16
`define WDT_STAT_BLANK      17

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define WDT_RST_DISABLE     1'b0
`define WDT_RST_RATE        1'b0
`define WDT_RST_STOP_EN     1'b1

// ----------------------------------------------------------------------------
// timing counts in oscillator cycles, and the oscillator frequency in Hz
// ----------------------------------------------------------------------------
`define WDT_LONG_LIMIT      18'h3fff0
`define WDT_SHORT_LIMIT     13'h1ff0
`define WDT_PULSE_OSC       32
`define WDT_POR_CLR_OSC     4096
`define WDT_OSC_HZ          47000

`endif

// File: include/wdt_pkg.sv
// types shared by the watchdog modules
package wdt_pkg;
    // software controls of the watchdog
    typedef struct packed {
        logic stop_enable;
        logic timeout_rate_select;
        logic watchdog_disable;
    } wdt_ctrl_t;

    // processor modes and test-voltage sensing
    typedef struct packed {
        logic stop_mode;
        logic monitor_mode;
        logic blank_vector_entry;
        logic break_state;
        logic irq_at_test_high_voltage;
        logic rst_at_test_high_voltage;
    } wdt_mode_t;

    // reset pin stretcher states
    typedef enum logic [0:0] {
        WDT_IDLE,
        WDT_DRIVE
    } wdt_pulse_st_t;
endpackage

// File: logic/wdt_ahb_slave.sv
// ahb-lite slave front end of the watchdog registers
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_ahb_slave
    import wdt_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // ahb-lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // register side
    input  wire logic [31:0] rd_ctrl,
    input  wire logic [31:0] rd_stat,
    input  wire logic [7:0]  rd_vector_lo,
    output logic             wr_ctrl,
    output logic             wr_stat,
    output logic             wr_service,
    output logic      [31:0] wdata
);
    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    function automatic logic wdt_hit(input logic [31:0] a, input logic [15:0] idx);
        return a[31:2] == {14'h0000, idx};
    endfunction

    // a valid transfer in the address phase
    wire       addr_go   = hsel & htrans[1] & hready;
    wire       hit_ctrl  = wdt_hit(haddr, `WDT_IDX_CTRL);
    wire       hit_stat  = wdt_hit(haddr, `WDT_IDX_STAT);
    wire       hit_svc   = wdt_hit(haddr, `WDT_IDX_SERVICE);
    wire [31:0] read_mux = hit_ctrl ? rd_ctrl :
                           hit_stat ? rd_stat :
                           hit_svc  ? {24'h000000, rd_vector_lo} : 32'h00000000;

    logic [2:0] wr_pend; // ctrl, stat, service writes awaiting data phase

    // zero wait states, always okay
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign wr_ctrl    = wr_pend[0];
    assign wr_stat    = wr_pend[1];
    assign wr_service = wr_pend[2];
    assign wdata      = hwdata;

    // latch write decode and read data at the address phase edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend <= 3'h0;
            hrdata  <= 32'h00000000;
        end else begin
            wr_pend <= {3{addr_go & hwrite}} & {hit_svc, hit_stat, hit_ctrl};
            hrdata  <= (addr_go & ~hwrite) ? read_mux : 32'h00000000;
        end
    end

    chk_single_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        $onehot0(wr_pend)) else $error("more than one register write strobe");
endmodule

// File: logic/wdt_rst_stretch.sv
// stretches a watchdog overflow into a reset pin pulse of fixed oscillator length
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_rst_stretch
    import wdt_pkg::*;
#(
    parameter int PULSE_TICKS = `WDT_PULSE_OSC
)(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // control
    input  wire logic trigger,
    input  wire logic osc_tick,
    output logic      driving
);
    initial begin
        if (PULSE_TICKS < 1 || PULSE_TICKS > 255) $error("PULSE_TICKS out of range");
    end

    localparam logic [7:0] LAST = 8'(PULSE_TICKS - 1);

    wdt_pulse_st_t st;
    logic [7:0]    ticks;

    assign driving = (st == WDT_DRIVE);

    // count raw oscillator ticks while the pin is held low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st    <= WDT_IDLE;
            ticks <= 8'h00;
        end else begin
            case (st)
                WDT_IDLE: begin
                    ticks <= 8'h00;
                    if (trigger) st <= WDT_DRIVE;
                end
                WDT_DRIVE: begin
                    if (osc_tick) begin
                        ticks <= ticks + 8'h01;
                        if (ticks == LAST) st <= WDT_IDLE;
                    end
                end
                default: st <= WDT_IDLE;
            endcase
        end
    end

    chk_pulse_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
        driving && osc_tick && ticks == LAST |=> !driving)
        else $error("reset pulse did not end after its tick count");
    chk_pulse_start: assert property (@(posedge sys_clk) disable iff (!resetn)
        !driving && trigger |=> driving && ticks == 8'h00)
        else $error("reset pulse did not start on trigger");
endmodule

// File: logic/wdt_top.sv
// watchdog timer: prescaler, counter, overflow reset and register access
// ----------------------------------------------------------------------------
// What this block does
// - six-bit counter fed by a twelve-bit prescaler, both stepped by oscillator ticks.
// - only the internal oscillator tick steps the prescaler and counter.
// - rate bit set gives 2^13-2^4 ticks, clear gives 2^18-2^4; reset clears it.
// - unserviced overflow raises a system reset request.
// - any write to the service port clears counter and prescaler stages 12..5.
// - reading the service port returns the reset vector low byte.
// - overflow holds the reset pin low 32 ticks and sets the cause bit.
// - stop clears the prescaler; stop mode blocks oscillator ticks.
// - 4096 ticks after power-up the prescaler is cleared.
// - internal reset clears both prescaler and counter.
// - reset vector fetch clears the prescaler.
// - disable bit set stops the watchdog; clear lets it run.
// - no interrupt request is ever raised; reset only.
// - monitor mode with test voltage disables; blank-vector entry disables until power-on.
// - break state with test voltage on reset pin disables the watchdog.
// - counting continues in wait mode; software services from interrupts.
// - stop with stop disabled gives an illegal opcode reset instead.
// ----------------------------------------------------------------------------
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top
    import wdt_pkg::*;
#(
    parameter int POR_TICKS   = `WDT_POR_CLR_OSC,
    parameter int PULSE_TICKS = `WDT_PULSE_OSC
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // ahb-lite register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timebase and processor events
    input  wire logic        osc_tick,
    input  wire logic        internal_reset,
    input  wire logic        vector_fetch,
    input  wire logic        stop_exec,
    input  wire logic [7:0]  reset_vector_lo,
    input  wire wdt_mode_t   mode,
    // reset outputs
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    output logic             wdt_reset_req,
    output logic             illegal_op_reset
);
    initial begin
        if (POR_TICKS < 1 || POR_TICKS > 8191) $error("POR_TICKS out of range");
    end

    localparam logic [12:0] POR_LAST = 13'(POR_TICKS - 1);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    wdt_ctrl_t   ctrl;
    logic [5:0]  cnt;           // watchdog counter
    logic [11:0] pre;           // prescaler
    logic        cause;         // watchdog cause bit
    logic        blank_lock;    // blank-vector monitor entry latch
    logic [12:0] por_ticks;
    logic        por_done;
    logic        rst_drive;

    wire         wr_ctrl;
    wire         wr_stat;
    wire         wr_service;
    wire  [31:0] wdata;

    // ------------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------------
    wire [31:0] rd_ctrl = {29'h00000000, ctrl.stop_enable, ctrl.timeout_rate_select,
                           ctrl.watchdog_disable};
    wire [31:0] rd_stat = {14'h0000, blank_lock, rst_drive, 2'h0, cnt, 7'h00, cause};

    wdt_ahb_slave u_bus (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .hsel         (hsel),
        .haddr        (haddr),
        .htrans       (htrans),
        .hwrite       (hwrite),
        .hsize        (hsize),
        .hwdata       (hwdata),
        .hready       (hready),
        .hrdata       (hrdata),
        .hreadyout    (hreadyout),
        .hresp        (hresp),
        .rd_ctrl      (rd_ctrl),
        .rd_stat      (rd_stat),
        .rd_vector_lo (reset_vector_lo),
        .wr_ctrl      (wr_ctrl),
        .wr_stat      (wr_stat),
        .wr_service   (wr_service),
        .wdata        (wdata)
    );

    // ------------------------------------------------------------------------
    // disable conditions and tick gating
    // ------------------------------------------------------------------------
    // test voltage under monitor or break parks the watchdog
    wire mon_tst  = mode.monitor_mode &
                    (mode.irq_at_test_high_voltage | mode.rst_at_test_high_voltage);
    wire brk_tst  = mode.break_state & mode.rst_at_test_high_voltage;
    wire disabled = ctrl.watchdog_disable | mon_tst | blank_lock | brk_tst;
    // stop mode removes the timebase; wait mode does not
    wire tick_en  = osc_tick & ~mode.stop_mode;
    wire stop_ok  = stop_exec & ctrl.stop_enable;
    wire por_clr  = tick_en & ~por_done & (por_ticks == POR_LAST);
    wire pre_clr  = stop_ok | vector_fetch | por_clr;
    wire advance  = tick_en & ~disabled & ~rst_drive;

    // ------------------------------------------------------------------------
    // overflow detect
    // ------------------------------------------------------------------------
    wire [17:0] full_val  = {cnt, pre};
    wire        at_long   = (full_val == `WDT_LONG_LIMIT - 18'h00001);
    wire        at_short  = (full_val[12:0] == `WDT_SHORT_LIMIT - 13'h0001);
    wire        at_limit  = ctrl.timeout_rate_select ? at_short : at_long;
    wire        quiet     = ~internal_reset & ~wr_service & ~pre_clr;
    wire        overflow  = advance & quiet & at_limit;

    // ------------------------------------------------------------------------
    // next counter value, clears by priority
    // ------------------------------------------------------------------------
    logic [17:0] next_val;
    always_comb begin
        next_val = full_val;
        if (internal_reset || disabled || overflow) begin
            next_val = 18'h00000;
        end else if (wr_service) begin
            next_val = {6'h00, 8'h00, pre[3:0]};
        end else if (pre_clr) begin
            next_val = {cnt, 12'h000};
        end else if (advance) begin
            next_val = full_val + 18'h00001;
        end
    end

    // counter and prescaler
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 6'h00;
            pre <= 12'h000;
        end else begin
            cnt <= next_val[17:12];
            pre <= next_val[11:0];
        end
    end

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl.watchdog_disable    <= `WDT_RST_DISABLE;
            ctrl.timeout_rate_select <= `WDT_RST_RATE;
            ctrl.stop_enable         <= `WDT_RST_STOP_EN;
        end else if (wr_ctrl) begin
            ctrl.watchdog_disable    <= wdata[`WDT_CTRL_DISABLE];
            ctrl.timeout_rate_select <= wdata[`WDT_CTRL_RATE];
            ctrl.stop_enable         <= wdata[`WDT_CTRL_STOP_EN];
        end
    end

    // ------------------------------------------------------------------------
    // cause bit and blank-vector latch
    // ------------------------------------------------------------------------
    // cause: set by overflow, write one clears, set wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cause <= 1'b0;
        end else if (overflow) begin
            cause <= 1'b1;
        end else if (wr_stat && wdata[`WDT_STAT_CAUSE]) begin
            cause <= 1'b0;
        end
    end

    // blank-vector monitor entry holds off the watchdog until power-on
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            blank_lock <= 1'b0;
        end else if (mode.monitor_mode && mode.blank_vector_entry) begin
            blank_lock <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // power-up prescaler clear
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            por_ticks <= 13'h0000;
            por_done  <= 1'b0;
        end else if (tick_en && !por_done) begin
            por_ticks <= por_ticks + 13'h0001;
            por_done  <= (por_ticks == POR_LAST);
        end
    end

    // ------------------------------------------------------------------------
    // stop handling: illegal opcode reset when stop is not allowed
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            illegal_op_reset <= 1'b0;
        end else begin
            illegal_op_reset <= stop_exec & ~ctrl.stop_enable;
        end
    end

    // ------------------------------------------------------------------------
    // reset pin driver, open drain
    // ------------------------------------------------------------------------
    wdt_rst_stretch #(
        .PULSE_TICKS (PULSE_TICKS)
    ) u_stretch (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .trigger  (overflow),
        .osc_tick (osc_tick),
        .driving  (rst_drive)
    );

    // only reset leaves this block, never an interrupt
    assign rst_pin_out   = 1'b0;
    assign rst_pin_oe    = rst_drive;
    assign wdt_reset_req = rst_drive;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_service_clear: assert property (wr_service && !internal_reset && !disabled
        |=> cnt == 6'h00 && pre[11:4] == 8'h00)
        else $error("service write did not clear counter");
    chk_service_priority: assert property (wr_service && advance && !internal_reset
        |=> full_val[17:4] == 14'h0000)
        else $error("advance won over service clear");
    chk_disable_hold: assert property (disabled |=> full_val == 18'h00000)
        else $error("disabled watchdog kept counting");
    chk_overflow_pin: assert property (overflow |=> rst_pin_oe && !rst_pin_out && cause)
        else $error("overflow did not drive reset pin and cause");
    chk_long_period: assert property (advance && quiet && !ctrl.timeout_rate_select
        && full_val == 18'h3ffef |-> overflow)
        else $error("long period overflow missed");
    chk_short_period: assert property (advance && quiet && ctrl.timeout_rate_select
        && full_val[12:0] == 13'h1fef |-> overflow)
        else $error("short period overflow missed");
    chk_int_reset: assert property (internal_reset |=> full_val == 18'h00000)
        else $error("internal reset did not clear watchdog");
    chk_pre_clear: assert property ((vector_fetch || stop_ok) && !wr_service
        && !internal_reset |=> pre == 12'h000)
        else $error("prescaler not cleared by fetch or stop");
    chk_stop_illegal: assert property (stop_exec && !ctrl.stop_enable
        |=> illegal_op_reset)
        else $error("stop with stop disabled gave no illegal opcode reset");
    chk_stop_gate: assert property (mode.stop_mode && !internal_reset && !wr_service
        && !pre_clr && !disabled |=> $stable(full_val))
        else $error("watchdog advanced in stop mode");

    cov_overflow: cover property (overflow);
    cov_service: cover property (wr_service ##1 advance);
    cov_por_clear: cover property (por_clr);
    cov_illegal_stop: cover property (illegal_op_reset);
endmodule

// File: sim/wdt_cpu_model.sv
// cpu core model: oscillator ticks, mode levels and event pulses
`timescale 1ns/1ps
module wdt_cpu_model
    import wdt_pkg::*;
(
    // clock
    input  wire logic sys_clk,
    // towards the watchdog
    output logic      osc_tick,
    output logic      internal_reset,
    output logic      vector_fetch,
    output logic      stop_exec,
    output wdt_mode_t mode
);
    // ------------------------------------------------------------------
    // oscillator tick on every second cycle, running free
    // ------------------------------------------------------------------
    initial begin
        osc_tick = 1'b0;
        {internal_reset, vector_fetch, stop_exec} = 3'b000;
        mode = '0;
        forever begin
            @(posedge sys_clk);
            osc_tick <= ~osc_tick;
        end
    end

    // one-cycle event pulse: internal_reset, vector_fetch, stop_exec
    task automatic pulse(input logic [2:0] sel);
        @(posedge sys_clk);
        {internal_reset, vector_fetch, stop_exec} <= sel;
        @(posedge sys_clk);
        {internal_reset, vector_fetch, stop_exec} <= 3'b000;
    endtask

    // mode levels change just after an edge
    task automatic set_mode(input wdt_mode_t m);
        @(posedge sys_clk);
        mode <= m;
    endtask
endmodule

// File: sim/wdt_top_tb.sv
// self-checking bench of the watchdog top level
`timescale 1ns/1ps
module wdt_top_tb
    import wdt_pkg::*;
;
    logic        sys_clk, resetn, hwrite, hsel;
    logic [7:0]  vec_lo;
    logic [31:0] haddr, hwdata, q;
    logic [1:0]  htrans;
    wire  [31:0] hrdata;
    wire         hreadyout, hready, hresp, osc_tick, internal_reset;
    wire         vector_fetch, stop_exec, rst_pin_oe, wdt_reset_req, illegal_op_reset;
    wire         rst_pin_out;
    wdt_mode_t   mode;
    int          failures, n_compared, cnt;
    logic [31:0] dis_ctrl [5] = '{32'h5, 32'h4, 32'h4, 32'h4, 32'h4};
    logic [5:0]  dis_mode [5] = '{6'h00, 6'h12, 6'h11, 6'h05, 6'h20};

    assign hready = hreadyout;

    wdt_top #(.POR_TICKS(4)) dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .osc_tick(osc_tick), .internal_reset(internal_reset),
        .vector_fetch(vector_fetch), .stop_exec(stop_exec),
        .reset_vector_lo(vec_lo), .mode(mode), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .wdt_reset_req(wdt_reset_req),
        .illegal_op_reset(illegal_op_reset));

    wdt_cpu_model cpu (.sys_clk(sys_clk), .osc_tick(osc_tick),
        .internal_reset(internal_reset), .vector_fetch(vector_fetch),
        .stop_exec(stop_exec), .mode(mode));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_ready;
        int i;
        i = 0;
        @(posedge sys_clk);
        while (hready !== 1'b1 && i < 100) begin
            @(posedge sys_clk);
            i++;
        end
    endtask

    // one single ahb-lite transfer
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        hsel <= 1'b1;
        htrans <= 2'b10;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
        q = hrdata;
        chk("bus response", 32'h0, {31'h0, hresp});
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk iff osc_tick === 1'b1);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock and timeout watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (96000) @(posedge sys_clk);
        failures++;
        $display("FAIL timeout expected done seen hang");
        report_and_stop;
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        {haddr, hwdata, htrans, hwrite, hsel} = '0;
        vec_lo = 8'ha5;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b1, 32'h3fffc, 32'h0);
        bus(1'b0, 32'h0, 32'h0);
        chk("ctrl reset", 32'h4, q);
        bus(1'b0, 32'h3fffc, 32'h0);
        chk("service read", 32'ha5, q);
        bus(1'b0, 32'h8, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test registers done");
        bus(1'b1, 32'h3fffc, 32'h0);
        ticks(4200);
        bus(1'b0, 32'h4, 32'h0);
        chk("count run", 32'h1, {26'h0, q[13:8]});
        cpu.pulse(3'b100);
        bus(1'b0, 32'h4, 32'h0);
        chk("count int reset", 32'h0, {26'h0, q[13:8]});
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 32'h0, dis_ctrl[i]);
            cpu.set_mode(wdt_mode_t'(dis_mode[i]));
            bus(1'b1, 32'h3fffc, 32'h0);
            ticks(4200);
            bus(1'b0, 32'h4, 32'h0);
            chk("count disabled", 32'h0, {26'h0, q[13:8]});
            cpu.set_mode('0);
        end
        $display("test disables done");
        for (int s = 1; s < 3; s++) begin
            bus(1'b1, 32'h3fffc, 32'h0);
            ticks(4000);
            cpu.pulse(s == 1 ? 3'b010 : 3'b001);
            ticks(150);
            bus(1'b0, 32'h4, 32'h0);
            chk("count prescaler clear", 32'h0, {26'h0, q[13:8]});
        end
        $display("test prescaler clears done");
        bus(1'b1, 32'h0, 32'h0);
        cpu.pulse(3'b001);
        @(posedge sys_clk);
        chk("illegal op", 32'h1, {31'h0, illegal_op_reset});
        bus(1'b1, 32'h0, 32'h6);
        bus(1'b1, 32'h3fffc, 32'h0);
        ticks(4000);
        bus(1'b1, 32'h3fffc, 32'h0);
        ticks(8159);
        chk("early reset", 32'h0, {31'h0, rst_pin_oe});
        cnt = 0;
        while (rst_pin_oe !== 1'b1 && cnt < 80) begin
            @(posedge sys_clk);
            cnt++;
        end
        chk("overflow reset", 32'h1, {31'h0, wdt_reset_req});
        cnt = 0;
        forever begin
            @(posedge sys_clk);
            if (rst_pin_oe !== 1'b1) break;
            if (osc_tick === 1'b1) cnt++;
        end
        chk("pin ticks", 32'd32, cnt);
        bus(1'b0, 32'h4, 32'h0);
        chk("cause set", 32'h1, {31'h0, q[0]});
        bus(1'b1, 32'h4, 32'h1);
        bus(1'b0, 32'h4, 32'h0);
        chk("cause clear", 32'h0, {31'h0, q[0]});
        $display("test overflow done");
        report_and_stop;
    end
endmodule
